// file: pkg/rmw_alu_pkg.sv
// Function
// RQ1: Subtract-borrow reads byte, subtracts carry, writes back
// RQ2: Subtract-borrow updates Z, C, AC, OV; memory result
// RQ3: Increment adds one, writes back, updates flags
// RQ4: Decrement subtracts one, writes back, updates flags
// RQ5: Clear writes zero into the addressed byte
// RQ6: Results wrap modulo 256; carry holds carry/borrow
package rmw_alu_pkg;

	localparam int DATA_W = 8;
	localparam int ADDR_W = 8;
	localparam int NIBBLE_W = 4;
	localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
	localparam logic [DATA_W-1:0] ONE_BYTE = 8'h01;
	localparam logic [3:0] FLAGS_RST = 4'h0;

	typedef enum logic [1:0] {
		OP_SUBC,
		OP_INC,
		OP_DEC,
		OP_CLEAR
	} rmw_op_t;

	typedef struct packed {
		logic ov;
		logic ac;
		logic c;
		logic z;
	} alu_flags_t;

	typedef struct packed {
		rmw_op_t op;
		logic [ADDR_W-1:0] addr;
	} rmw_req_t;

endpackage

// file: logic/memory_rmw_alu_ops.sv
module memory_rmw_alu_ops
	import rmw_alu_pkg::*;
#(
	parameter int DATA_BITS = DATA_W,
	parameter int ADDR_BITS = ADDR_W
)
(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic start_i,
	input wire rmw_req_t req_i,
	input wire alu_flags_t flags_i,
	output logic busy_o,
	output logic mem_rd_o,
	output logic [ADDR_W-1:0] mem_addr_o,
	input wire logic [DATA_W-1:0] mem_rdata_i,
	output logic mem_wr_o,
	output logic [DATA_W-1:0] mem_wdata_o,
	output logic done_o,
	output logic flags_we_o,
	output alu_flags_t flags_o
);

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_READ,
		ST_WRITE
	} state_t;

	// Request fields are latched at issue; the decoder may move them while busy
	state_t state_r, state_nxt;
	rmw_op_t op_r, op_nxt;
	logic [ADDR_W-1:0] addr_r, addr_nxt;
	logic carry_in_r, carry_in_nxt;
	logic rd_r, rd_nxt;
	logic wr_r, wr_nxt;
	logic done_r, done_nxt;
	logic fwe_r, fwe_nxt;
	logic [DATA_W-1:0] wdata_r, wdata_nxt;
	alu_flags_t flags_r, flags_nxt;

	////////////////////////////////////////////////////////////////////////
	// Elaboration checks

	// The request struct and the byte constants fix both widths
	if (DATA_BITS != DATA_W) begin : g_bad_data_bits
		$error("DATA_BITS must match the package data width");
	end
	if (ADDR_BITS != ADDR_W) begin : g_bad_addr_bits
		$error("ADDR_BITS must match the request address width");
	end
	// Auxiliary carry needs a bit above the low nibble
	if (DATA_BITS <= NIBBLE_W) begin : g_bad_nibble
		$error("DATA_BITS must exceed the nibble width");
	end

	////////////////////////////////////////////////////////////////////////
	// Opcode decoding shared by the datapath and the sequencer

	function automatic logic op_subtracts(input rmw_op_t op);
		return (op == OP_SUBC) || (op == OP_DEC);
	endfunction

	function automatic logic op_reads_memory(input rmw_op_t op);
		// Clear discards the old byte, so it skips the read cycle
		return (op != OP_CLEAR);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Arithmetic: one adder serves all three arithmetic ops

	logic [DATA_W-1:0] operand;
	logic sub_mode;
	logic [DATA_W:0] full_res;
	logic [NIBBLE_W:0] half_res;
	logic [DATA_W-1:0] result;
	wire [DATA_BITS:0] nonzero_chain;
	alu_flags_t calc_flags;

	// One adder serves all three ops; the operand is never above one
	always_comb begin
		operand = ZERO_BYTE;
		sub_mode = op_subtracts(op_r);
		case (op_r)
			OP_SUBC: begin
				operand = {{(DATA_W-1){1'b0}}, carry_in_r}; // RQ1
			end
			OP_INC: begin
				operand = ONE_BYTE; // RQ3
			end
			OP_DEC: begin
				operand = ONE_BYTE; // RQ4
			end
			default: begin
				operand = ZERO_BYTE;
			end
		endcase
		// Carry is borrow for subtraction, carry-out for addition
		if (sub_mode) begin
			full_res = {1'b0, mem_rdata_i} - {1'b0, operand}; // RQ6
			half_res = {1'b0, mem_rdata_i[NIBBLE_W-1:0]} - {1'b0, operand[NIBBLE_W-1:0]};
		end else begin
			full_res = {1'b0, mem_rdata_i} + {1'b0, operand}; // RQ6
			half_res = {1'b0, mem_rdata_i[NIBBLE_W-1:0]} + {1'b0, operand[NIBBLE_W-1:0]};
		end
		result = full_res[DATA_W-1:0]; // RQ6
	end

	// Zero detect as an OR ripple, short enough at byte width
	assign nonzero_chain[0] = 1'b0;
	for (genvar b = 0; b < DATA_BITS; b++) begin : g_zero_detect
		assign nonzero_chain[b+1] = nonzero_chain[b] | result[b];
	end

	////////////////////////////////////////////////////////////////////////
	// Flags from the shared adder

	always_comb begin
		calc_flags.z = ~nonzero_chain[DATA_BITS]; // RQ2
		calc_flags.c = full_res[DATA_W]; // RQ2
		calc_flags.ac = half_res[NIBBLE_W]; // RQ2
		// Signed overflow: operand sign agrees (add) or differs (sub), result differs
		calc_flags.ov = (mem_rdata_i[DATA_W-1] ^ operand[DATA_W-1] ^ ~sub_mode)
			& (result[DATA_W-1] ^ mem_rdata_i[DATA_W-1]); // RQ2
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer: arithmetic reads, then writes back with flag update; clear skips the read and the flags
	// Arithmetic: read strobe, write and flag pulse, then done
	// Clear: write, then done; the next start may share the done cycle

	always_comb begin
		state_nxt = state_r;
		op_nxt = op_r;
		addr_nxt = addr_r;
		carry_in_nxt = carry_in_r;
		rd_nxt = 1'b0;
		wr_nxt = 1'b0;
		done_nxt = 1'b0;
		fwe_nxt = 1'b0;
		wdata_nxt = wdata_r;
		flags_nxt = flags_r;
		// A start outside ST_IDLE is dropped: there is no request queue
		case (state_r)
			ST_IDLE: begin
				if (start_i) begin
					op_nxt = req_i.op;
					addr_nxt = req_i.addr;
					// Carry is latched at issue so a later flag write cannot skew it
					carry_in_nxt = flags_i.c;
					if (!op_reads_memory(req_i.op)) begin
						// No read needed: the old contents are discarded
						wdata_nxt = ZERO_BYTE; // RQ5
						wr_nxt = 1'b1; // RQ5
						state_nxt = ST_WRITE;
					end else begin
						rd_nxt = 1'b1;
						state_nxt = ST_READ;
					end
				end
			end
			ST_READ: begin
				// Memory answers within the strobe cycle; a registered memory needs a wait state
				wdata_nxt = result; // RQ1
				wr_nxt = 1'b1; // RQ1
				// Clear never passes here, so it leaves the flags untouched
				fwe_nxt = 1'b1; // RQ2
				flags_nxt = calc_flags; // RQ2
				state_nxt = ST_WRITE;
			end
			ST_WRITE: begin
				done_nxt = 1'b1;
				state_nxt = ST_IDLE;
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// State registers: synchronous reset, no enable

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state_r <= ST_IDLE;
			op_r <= OP_SUBC;
			addr_r <= '0;
			carry_in_r <= 1'b0;
			rd_r <= 1'b0;
			wr_r <= 1'b0;
			done_r <= 1'b0;
			fwe_r <= 1'b0;
			wdata_r <= ZERO_BYTE;
			flags_r <= FLAGS_RST;
		end else begin
			state_r <= state_nxt;
			op_r <= op_nxt;
			addr_r <= addr_nxt;
			carry_in_r <= carry_in_nxt;
			rd_r <= rd_nxt;
			wr_r <= wr_nxt;
			done_r <= done_nxt;
			fwe_r <= fwe_nxt;
			wdata_r <= wdata_nxt;
			flags_r <= flags_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs: busy is decoded from state, everything else is a flop

	assign busy_o = (state_r != ST_IDLE);
	assign mem_rd_o = rd_r;
	assign mem_wr_o = wr_r;
	assign mem_addr_o = addr_r;
	assign mem_wdata_o = wdata_r;
	assign done_o = done_r;
	assign flags_we_o = fwe_r;
	assign flags_o = flags_r;

endmodule // memory_rmw_alu_ops

// file: testbench/rmw_mem_model.sv
module rmw_mem_model (
	input logic clk_i,
	input logic mem_rd_o,
	input logic [7:0] mem_addr_o,
	input logic mem_wr_o,
	input logic [7:0] mem_wdata_o,
	output logic [7:0] mem_rdata_i
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] mem [256];
	logic [7:0] last_rd = 8'h00;
	initial for (int i = 0; i < 256; i++) mem[i] = 8'(i << 6);
	// Answers within the strobe cycle, the slot the datapath samples;
	// outside it the bus shows the inverse of the last byte, so a late sample shows up
	assign mem_rdata_i = mem_rd_o ? mem[mem_addr_o] : ~last_rd;
	always @(posedge clk_i) begin
		if (mem_rd_o) last_rd <= mem[mem_addr_o];
		if (mem_wr_o) mem[mem_addr_o] <= mem_wdata_o;
	end
endmodule // rmw_mem_model

// file: testbench/memory_rmw_alu_ops_monitor.sv
module memory_rmw_alu_ops_monitor
	import rmw_alu_pkg::*;
(
	input logic clk_i,
	input logic sys_rst_i,
	input logic start_i,
	input rmw_req_t req_i,
	input alu_flags_t flags_i,
	input logic busy_o,
	input logic mem_rd_o,
	input logic [7:0] mem_addr_o,
	input logic [7:0] mem_rdata_i,
	input logic mem_wr_o,
	input logic [7:0] mem_wdata_o,
	input logic done_o,
	input logic flags_we_o,
	input alu_flags_t flags_o
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	wire g = start_i && !busy_o;
	property p_rd; g && req_i.op != OP_CLEAR |=> mem_rd_o && mem_addr_o == $past(req_i.addr);
	endproperty
	property p_clr; g && req_i.op == OP_CLEAR |=> mem_wr_o && !mem_rd_o && mem_wdata_o == 8'h00;
	endproperty
	property p_wr; mem_rd_o |-> ##[1:2] mem_wr_o && flags_we_o; endproperty
	property p_z; flags_we_o |-> mem_wr_o && flags_o.z == (mem_wdata_o == 8'h00); endproperty
	property p_done; mem_wr_o |=> done_o && !busy_o; endproperty
	property p_ov; flags_we_o && flags_o.ov |-> mem_wdata_o inside {8'h80, 8'h7f}; endproperty
	a_rd: assert property (p_rd) else $error("no read");
	a_clr: assert property (p_clr) else $error("bad clear");
	a_wr: assert property (p_wr) else $error("no write");
	a_z: assert property (p_z) else $error("bad zero");
	a_done: assert property (p_done) else $error("no done");
	a_ov: assert property (p_ov) else $error("bad ov");
	c_clr: cover property (g && req_i.op == OP_CLEAR);
	c_ov: cover property (flags_we_o && flags_o.ov);
	c_brw: cover property (flags_we_o && flags_o.c);
endmodule // memory_rmw_alu_ops_monitor
bind memory_rmw_alu_ops memory_rmw_alu_ops_monitor memory_rmw_alu_ops_monitor_i (.*);

// file: testbench/tb_memory_rmw_alu_ops.sv
module tb_memory_rmw_alu_ops
	import rmw_alu_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_i = 0, sys_rst_i = 1, start_i = 0, busy_o, mem_rd_o, mem_wr_o, done_o, flags_we_o;
	rmw_req_t req_i = '0;
	alu_flags_t flags_i = '0, flags_o, lf = '0;
	logic [7:0] mem_addr_o, mem_rdata_i, mem_wdata_o, m [256];
	logic [8:0] e;
	int failures = 0, checks_done = 0, seed = 32'h316b, n;
	always #12.5 clk_i = ~clk_i;
	memory_rmw_alu_ops memory_rmw_alu_ops_i (.*);
	rmw_mem_model rmw_mem_model_i (.*);
	task results;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task wt(input bit sel);
		for (n = 0; n < 9 && (sel ? done_o : mem_wr_o) !== 1'b1; n++) @(negedge clk_i);
		if (n == 9) begin
			failures++;
			results;
		end
	endtask
	task chk(logic [20:0] g, x);
		checks_done++;
		if (g !== x) begin
			failures++;
			$display("CHECK FAILED %0t got %h exp %h", $time, g, x);
		end
	endtask
	task run(rmw_op_t o, logic [7:0] a);
		@(posedge clk_i);
		start_i <= 1;
		req_i <= '{o, a};
		flags_i <= 4'($random(seed));
		@(posedge clk_i);
		start_i <= 0;
		// Request pins wander while busy; the design must hold its own copy
		req_i <= rmw_req_t'(10'($random(seed)));
		@(negedge clk_i);
		wt(1'b0);
		e = o == OP_INC ? m[a] + 9'h1 : {1'b0, m[a]} - (o == OP_SUBC ? flags_i.c : 1'b1);
		// Carry into bit 4 is a[4]^r[4], since the operand is at most one
		if (o == OP_CLEAR) e = 9'h0;
		else lf = {{m[a], e[7:0]} inside {16'h7f80, 16'h807f}, m[a][4] ^ e[4], e[8], e[7:0] == 0};
		chk({mem_addr_o, flags_we_o, flags_o, mem_wdata_o}, {a, o != OP_CLEAR, lf, e[7:0]});
		m[a] = e[7:0];
		wt(1'b1);
	endtask
	initial begin
		for (int i = 0; i < 256; i++) m[i] = 8'(i << 6);
		repeat (16) @(posedge clk_i);
		sys_rst_i <= 0;
		repeat (400) run(rmw_op_t'(2'($random(seed))), {5'h0, 3'($random(seed))});
		results;
	end
endmodule // tb_memory_rmw_alu_ops
